// File: mode_reset_pkg.sv
package mode_reset_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [3:0] mode_control_offset        = 4'h0;
	localparam logic [3:0] chip_identification_offset = 4'h4;
	localparam logic [3:0] reset_cause_status_offset  = 4'h8;

	// ************************************************************
	// Mode register field positions
	// ************************************************************
	localparam int boot_remap_flag_bit        = 0;
	localparam int dsp_a_reset_ctl_bit        = 1;
	localparam int dsp_b_reset_ctl_bit        = 2;
	localparam int dsp_a_clock_gate_bit       = 3;
	localparam int dsp_b_clock_gate_bit       = 4;
	localparam int sync_clock_bit             = 5;
	localparam int low_power_flag_bit         = 6;
	localparam int low_power_divider_pick_lsb = 8;
	localparam int soft_reset_rom_on_bit      = 10;
	localparam int soft_reset_rom_off_bit     = 11;
	localparam int dsp_a_debug_bit            = 12;
	localparam int dsp_b_debug_bit            = 13;
	localparam int codec_a_reset_ctl_bit      = 14;
	localparam int codec_b_reset_ctl_bit      = 15;
	localparam int package_flag_bit           = 16;

	// ************************************************************
	// Reset values and cause codes
	// ************************************************************
	localparam logic [2:0] cause_hardware = 3'h1;
	localparam logic [2:0] cause_watchdog = 3'h2;
	localparam logic [2:0] cause_software = 3'h4;
	localparam logic [2:0] version_reset  = 3'h1; // Arbitrary neutral value

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int clock_mhz             = 125;
	localparam int min_reset_cycles      = 10;
	localparam int dsp_release_toggles   = 6;
	localparam logic [3:0] pulse_cycles  = 4'(min_reset_cycles);

	// Low-power divisors per code
	localparam logic [10:0] divisor_code0 = 11'h001;
	localparam logic [10:0] divisor_code1 = 11'h020;
	localparam logic [10:0] divisor_code2 = 11'h080;
	localparam logic [10:0] divisor_code3 = 11'h400;

	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic        select;
		logic        write;
		logic [3:0]  addr;
		logic [31:0] wdata;
	} reg_request_t;

	typedef struct packed {
		logic dsp_a_reset_n;
		logic dsp_b_reset_n;
		logic dsp_a_clock_run;
		logic dsp_b_clock_run;
		logic dsp_a_debug;
		logic dsp_b_debug;
		logic codec_a_reset_n;
		logic codec_b_reset_n;
		logic sync_clock;
		logic dram_clock_run;
		logic rom_at_zero;
	} control_out_t;

	typedef enum logic [1:0] {
		cause_none,
		cause_hw,
		cause_wd,
		cause_sw
	} reset_source_t;

endpackage

// File: reset_pulse_stretch.sv
`timescale 1ns/10ps
// Stretches a one-cycle request to a reset pulse of fixed length
module reset_pulse_stretch #(
	parameter logic [3:0] length = 4'hA
) (
	input  wire logic clock,
	input  wire logic srst,
	input  wire logic trigger,
	output logic      pulse
);

	logic [3:0] count;

	// Down counter holds pulse while above one
	always_ff @(posedge clock) begin
		if (srst) begin
			count <= 4'h0;
		end else if (trigger) begin
			count <= length;
		end else if (count != 4'h0) begin
			count <= count - 4'h1;
		end
	end

	// Pulse covers the trigger cycle and the count down
	always_ff @(posedge clock) begin
		if (srst) begin
			pulse <= 1'b0;
		end else begin
			pulse <= trigger || (count > 4'h1);
		end
	end

endmodule

// File: mode_reset_controller.sv
`timescale 1ns/10ps
// Functional notes
// RULE1: Chip reset comes from reset pin, watchdog pulse or software write.
// RULE2: The reset pin must be held at least ten clock cycles.
// RULE3: With dynamic memory, hold reset about two hundred microseconds.
// RULE4: Any reset restores registers to defaults and restarts fetch at zero.
// RULE5: Boot-select pin sampled at release; low maps ROM at zero.
// RULE6: Remap flag loads boot-select at release; software may set it.
// RULE7: DSP cores stay in reset until software releases them.
// RULE8: DSP reset bits reset low; 010101 toggle pattern forwarded to core.
// RULE9: DSP clock-inhibit bits reset low; high stops that core clock.
// RULE10: Default asynchronous clocking, processor and DSP from separate PLLs.
// RULE11: Synchronous-clock bit runs processor and DSPs from DSP PLL.
// RULE12: Low-power divides processor clock and stops dynamic memory clock.
// RULE13: Low-power bit is set-only; only reset clears it.
// RULE14: Divider pick captured when low-power rises, frozen afterwards.
// RULE15: Divider codes 0..3 give divisors 1, 32, 128, 1024.
// RULE16: DSP debug bits reset low; set muxes test signals out.
// RULE17: Codec reset bits reset low; high releases the codec interface.
// RULE18: First software reset bit resets chip with remap flag zero.
// RULE19: Second software reset bit resets chip with remap flag one.
// RULE20: Failed serial boot handshake falls back to external memory boot.
// RULE21: Reset status holds one-hot cause: hardware, watchdog, software.
// RULE22: Identification register shows package flag and version field.
// RULE23: Software and watchdog requests become a timed internal reset pulse.
module mode_reset_controller #(
	parameter logic [2:0] version_value = mode_reset_pkg::version_reset
) (
	input  wire logic                         clock,
	input  wire logic                         srst,
	input  wire logic                         reset_pin,
	input  wire logic                         watchdog_pulse,
	input  wire logic                         boot_select_pin,
	input  wire logic                         bus_width_strap,
	input  wire logic                         boot_fail,
	input  wire mode_reset_pkg::reg_request_t req,
	output logic [31:0]                       rdata,
	output mode_reset_pkg::control_out_t      ctl,
	output logic                              chip_reset,
	output logic                              cpu_clock_enable,
	output logic [10:0]                       cpu_divisor
);
	import mode_reset_pkg::*;

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [1:0] pin_sync;
	logic [1:0] boot_sync;
	logic [1:0] wd_sync;
	logic       wd_seen;

	always_ff @(posedge clock) begin
		pin_sync  <= {pin_sync[0], reset_pin};
		boot_sync <= {boot_sync[0], boot_select_pin};
		wd_sync   <= {wd_sync[0], watchdog_pulse};
		wd_seen   <= wd_sync[1];
	end

	// ************************************************************
	// Reset sources and stretched internal reset
	// ************************************************************
	logic          mode_write;
	logic          sw_on_req;
	logic          sw_off_req;
	logic          wd_req;
	logic          stretch_pulse;
	logic          internal_reset;
	logic          internal_reset_q;
	logic          pending_remap;
	reset_source_t last_source;

	assign mode_write = req.select && req.write && (req.addr == mode_control_offset);
	assign sw_on_req  = mode_write && req.wdata[soft_reset_rom_on_bit];
	assign sw_off_req = mode_write && req.wdata[soft_reset_rom_off_bit];
	assign wd_req     = wd_sync[1] && !wd_seen;

	// Watchdog and software requests become a pulse of pin length
	reset_pulse_stretch #(
		.length (pulse_cycles)
	) u_stretch (
		.clock   (clock),
		.srst    (srst),
		.trigger (sw_on_req || sw_off_req || wd_req), // see RULE23
		.pulse   (stretch_pulse)
	);

	assign internal_reset = srst || pin_sync[1] || stretch_pulse; // see RULE1

	// Record which source fired and what remap a soft reset requests
	always_ff @(posedge clock) begin
		if (srst || pin_sync[1]) begin
			last_source   <= cause_hw;
			pending_remap <= 1'b0;
		end else if (sw_on_req) begin
			last_source   <= cause_sw;
			pending_remap <= 1'b0; // see RULE18
		end else if (sw_off_req) begin
			last_source   <= cause_sw;
			pending_remap <= 1'b1; // see RULE19
		end else if (wd_req) begin
			last_source   <= cause_wd;
			pending_remap <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		internal_reset_q <= internal_reset;
		chip_reset       <= internal_reset; // see RULE4
	end

	// ************************************************************
	// Mode register
	// ************************************************************
	logic       remap_flag;
	logic       dsp_a_reset_ctl;
	logic       dsp_b_reset_ctl;
	logic       dsp_a_clock_gate;
	logic       dsp_b_clock_gate;
	logic       sync_clock;
	logic       low_power_flag;
	logic [1:0] low_power_divider_pick;
	logic       dsp_a_debug;
	logic       dsp_b_debug;
	logic       codec_a_reset_ctl;
	logic       codec_b_reset_ctl;
	logic       release_edge;
	logic       boot_fallback;

	assign release_edge = internal_reset_q && !internal_reset;

	// Remap flag: sampled at release, soft reset override, software set
	always_ff @(posedge clock) begin
		if (internal_reset) begin
			remap_flag <= 1'b0;
		end else if (release_edge) begin
			if (last_source == cause_sw) begin
				remap_flag <= pending_remap; // see RULE18 see RULE19
			end else begin
				remap_flag <= boot_sync[1]; // see RULE5 see RULE6
			end
		end else if (boot_fallback) begin
			remap_flag <= 1'b1; // see RULE20
		end else if (mode_write) begin
			remap_flag <= remap_flag | req.wdata[boot_remap_flag_bit]; // see RULE6
		end
	end

	// Failed handshake unmaps the ROM so fetch goes to external memory
	always_ff @(posedge clock) begin
		if (internal_reset) begin
			boot_fallback <= 1'b0;
		end else begin
			boot_fallback <= boot_fail && !remap_flag; // see RULE20
		end
	end

	// Plain read/write control bits, all clear on reset
	always_ff @(posedge clock) begin
		if (internal_reset) begin
			dsp_a_reset_ctl   <= 1'b0; // see RULE7 see RULE8
			dsp_b_reset_ctl   <= 1'b0;
			dsp_a_clock_gate  <= 1'b0; // see RULE9
			dsp_b_clock_gate  <= 1'b0;
			sync_clock        <= 1'b0; // see RULE10
			dsp_a_debug       <= 1'b0; // see RULE16
			dsp_b_debug       <= 1'b0;
			codec_a_reset_ctl <= 1'b0; // see RULE17
			codec_b_reset_ctl <= 1'b0;
		end else if (mode_write) begin
			dsp_a_reset_ctl   <= req.wdata[dsp_a_reset_ctl_bit];
			dsp_b_reset_ctl   <= req.wdata[dsp_b_reset_ctl_bit];
			dsp_a_clock_gate  <= req.wdata[dsp_a_clock_gate_bit];
			dsp_b_clock_gate  <= req.wdata[dsp_b_clock_gate_bit];
			sync_clock        <= req.wdata[sync_clock_bit]; // see RULE11
			dsp_a_debug       <= req.wdata[dsp_a_debug_bit];
			dsp_b_debug       <= req.wdata[dsp_b_debug_bit];
			codec_a_reset_ctl <= req.wdata[codec_a_reset_ctl_bit];
			codec_b_reset_ctl <= req.wdata[codec_b_reset_ctl_bit];
		end
	end

	// Low-power is set-only; divider pick frozen at the rising edge
	always_ff @(posedge clock) begin
		if (internal_reset) begin
			low_power_flag         <= 1'b0;
			low_power_divider_pick <= 2'h0;
		end else if (mode_write && !low_power_flag && req.wdata[low_power_flag_bit]) begin
			low_power_flag         <= 1'b1; // see RULE13
			low_power_divider_pick <= req.wdata[low_power_divider_pick_lsb +: 2]; // see RULE14
		end
	end

	// ************************************************************
	// DSP release pattern: six toggles of the control bit
	// ************************************************************
	logic [2:0] toggles_a;
	logic [2:0] toggles_b;
	logic       prev_a;
	logic       prev_b;

	// Forward the bit to the core, count edges of the sequence
	always_ff @(posedge clock) begin
		if (internal_reset) begin
			toggles_a <= 3'h0;
			toggles_b <= 3'h0;
			prev_a    <= 1'b0;
			prev_b    <= 1'b0;
		end else begin
			prev_a <= dsp_a_reset_ctl;
			prev_b <= dsp_b_reset_ctl;
			if (dsp_a_reset_ctl != prev_a && toggles_a != 3'(dsp_release_toggles)) begin
				toggles_a <= toggles_a + 3'h1; // see RULE8
			end
			if (dsp_b_reset_ctl != prev_b && toggles_b != 3'(dsp_release_toggles)) begin
				toggles_b <= toggles_b + 3'h1;
			end
		end
	end

	// ************************************************************
	// Low-power divider
	// ************************************************************
	function automatic logic [10:0] pick_divisor(input logic [1:0] code);
		logic [10:0] result;
		result = divisor_code0;
		if (code == 2'h1) begin
			result = divisor_code1;
		end else if (code == 2'h2) begin
			result = divisor_code2;
		end else if (code == 2'h3) begin
			result = divisor_code3;
		end
		return result;
	endfunction

	logic [10:0] div_count;
	logic [10:0] active_divisor;

	assign active_divisor = low_power_flag ? pick_divisor(low_power_divider_pick) : divisor_code0; // see RULE15

	// Processor clock enable pulses once per divisor period
	always_ff @(posedge clock) begin
		if (internal_reset) begin
			div_count        <= 11'h000;
			cpu_clock_enable <= 1'b1;
			cpu_divisor      <= divisor_code0;
		end else begin
			cpu_divisor <= active_divisor; // see RULE12
			if (div_count + 11'h001 >= active_divisor) begin
				div_count        <= 11'h000;
				cpu_clock_enable <= 1'b1;
			end else begin
				div_count        <= div_count + 11'h001;
				cpu_clock_enable <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Control outputs
	// ************************************************************
	always_ff @(posedge clock) begin
		if (internal_reset) begin
			ctl <= '0;
			ctl.dram_clock_run  <= 1'b1;
			ctl.dsp_a_clock_run <= 1'b1;
			ctl.dsp_b_clock_run <= 1'b1;
		end else begin
			ctl.dsp_a_reset_n   <= dsp_a_reset_ctl; // see RULE8
			ctl.dsp_b_reset_n   <= dsp_b_reset_ctl;
			ctl.dsp_a_clock_run <= !dsp_a_clock_gate; // see RULE9
			ctl.dsp_b_clock_run <= !dsp_b_clock_gate;
			ctl.dsp_a_debug     <= dsp_a_debug; // see RULE16
			ctl.dsp_b_debug     <= dsp_b_debug;
			ctl.codec_a_reset_n <= codec_a_reset_ctl; // see RULE17
			ctl.codec_b_reset_n <= codec_b_reset_ctl;
			ctl.sync_clock      <= sync_clock; // see RULE11
			ctl.dram_clock_run  <= !low_power_flag; // see RULE12
			ctl.rom_at_zero     <= !remap_flag; // see RULE5
		end
	end

	// ************************************************************
	// Reset cause status and read path
	// ************************************************************
	logic [2:0] reset_cause;
	logic       strap_package;

	// Cause latched at the end of every reset; software may rewrite it
	always_ff @(posedge clock) begin
		if (release_edge) begin
			if (last_source == cause_sw) begin
				reset_cause <= cause_software; // see RULE21
			end else if (last_source == cause_wd) begin
				reset_cause <= cause_watchdog;
			end else begin
				reset_cause <= cause_hardware;
			end
		end else if (!internal_reset && req.select && req.write && req.addr == reset_cause_status_offset) begin
			reset_cause <= req.wdata[2:0];
		end
	end

	// Package strap caught while reset stands
	always_ff @(posedge clock) begin
		if (internal_reset) begin
			strap_package <= bus_width_strap; // see RULE22
		end
	end

	// Registered read data; unmapped offsets read zero
	always_ff @(posedge clock) begin
		if (internal_reset) begin
			rdata <= 32'h0000_0000;
		end else if (req.select && req.addr == mode_control_offset) begin
			rdata <= {16'h0000, codec_b_reset_ctl, codec_a_reset_ctl, dsp_b_debug, dsp_a_debug,
				2'h0, low_power_divider_pick, 1'b0, low_power_flag, sync_clock,
				dsp_b_clock_gate, dsp_a_clock_gate, dsp_b_reset_ctl, dsp_a_reset_ctl, remap_flag};
		end else if (req.select && req.addr == chip_identification_offset) begin
			rdata <= {15'h0000, strap_package, 13'h0000, version_value}; // see RULE22
		end else if (req.select && req.addr == reset_cause_status_offset) begin
			rdata <= {29'h0000_0000, reset_cause}; // see RULE21
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	low_power_sticky_a: assert property (@(posedge clock) disable iff (internal_reset)
		low_power_flag |=> low_power_flag) else $error("low power cleared without reset"); // see RULE13
	divider_frozen_a: assert property (@(posedge clock) disable iff (internal_reset)
		low_power_flag && $past(low_power_flag) |-> $stable(low_power_divider_pick))
		else $error("divider pick changed in low power"); // see RULE14
	soft_pulse_len_a: assert property (@(posedge clock) disable iff (srst || pin_sync[1])
		$rose(sw_on_req) |=> stretch_pulse [*8]) else $error("soft reset pulse too short"); // see RULE23
	dram_stop_a: assert property (@(posedge clock) disable iff (internal_reset)
		low_power_flag |=> !ctl.dram_clock_run) else $error("dram clock runs in low power"); // see RULE12
	clock_gate_a: assert property (@(posedge clock) disable iff (internal_reset)
		dsp_a_clock_gate |=> !ctl.dsp_a_clock_run) else $error("dsp clock not gated"); // see RULE9
	soft_remap_a: assert property (@(posedge clock)
		release_edge && last_source == cause_sw && pending_remap |=> remap_flag)
		else $error("soft reset remap wrong"); // see RULE19
	hw_cause_a: assert property (@(posedge clock)
		release_edge && last_source == cause_hw |=> reset_cause == cause_hardware)
		else $error("hardware cause wrong"); // see RULE21
	dsp_held_a: assert property (@(posedge clock)
		$fell(internal_reset) |-> !dsp_a_reset_ctl && !dsp_b_reset_ctl)
		else $error("dsp released by reset"); // see RULE7
	codec_follow_a: assert property (@(posedge clock) disable iff (internal_reset)
		codec_a_reset_ctl |=> ctl.codec_a_reset_n) else $error("codec not released"); // see RULE17

	low_power_entry_c: cover property (@(posedge clock) $rose(low_power_flag));
	soft_reset_c: cover property (@(posedge clock) sw_off_req);
	watchdog_reset_c: cover property (@(posedge clock) wd_req);
	dsp_release_c: cover property (@(posedge clock) toggles_a == 3'(dsp_release_toggles));

endmodule

// File: mode_reset_controller_tb.sv
`timescale 1ns/10ps
`define check(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin failures++; $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module mode_reset_controller_tb;
	import mode_reset_pkg::*;
	// ****************************************
	// Signals and design instance
	// ****************************************
	logic         clock;
	logic         srst;
	logic         reset_pin;
	logic         watchdog_pulse;
	logic         boot_select_pin;
	logic         bus_width_strap;
	logic         boot_fail;
	reg_request_t req;
	logic [31:0]  rdata;
	control_out_t ctl;
	logic         chip_reset;
	logic         cpu_clock_enable;
	logic [10:0]  cpu_divisor;
	int           failures;
	int           samples_checked;
	int           seed;
	logic [31:0]  d;
	logic [31:0]  w;
	int           p;
	localparam logic [2:0] ver = 3'h5; // Arbitrary version value
	localparam logic [31:0] mask = 32'h0000F03E;

	mode_reset_controller #(.version_value(ver)) dut (.clock(clock), .srst(srst), .reset_pin(reset_pin),
		.watchdog_pulse(watchdog_pulse), .boot_select_pin(boot_select_pin), .bus_width_strap(bus_width_strap),
		.boot_fail(boot_fail), .req(req), .rdata(rdata), .ctl(ctl), .chip_reset(chip_reset),
		.cpu_clock_enable(cpu_clock_enable), .cpu_divisor(cpu_divisor));

	// Free running 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// ****************************************
	// Bench helpers
	// ****************************************
	task automatic final_report();
		if (failures == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		tick(1);
		req = '{1'b1, 1'b1, a, v};
		tick(1);
		req.select = 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		tick(1);
		req = '{1'b1, 1'b0, a, 32'h00000000};
		tick(1);
		v = rdata;
		req.select = 1'b0;
	endtask

	// Expected control outputs for a mode word
	function automatic control_out_t exp_ctl(input logic [31:0] m, input logic rom);
		control_out_t c;
		c.dsp_a_reset_n   = m[dsp_a_reset_ctl_bit];
		c.dsp_b_reset_n   = m[dsp_b_reset_ctl_bit];
		c.dsp_a_clock_run = ~m[dsp_a_clock_gate_bit];
		c.dsp_b_clock_run = ~m[dsp_b_clock_gate_bit];
		c.dsp_a_debug     = m[dsp_a_debug_bit];
		c.dsp_b_debug     = m[dsp_b_debug_bit];
		c.codec_a_reset_n = m[codec_a_reset_ctl_bit];
		c.codec_b_reset_n = m[codec_b_reset_ctl_bit];
		c.sync_clock      = m[sync_clock_bit];
		c.dram_clock_run  = 1'b1;
		c.rom_at_zero     = rom;
		return c;
	endfunction

	function automatic logic [10:0] div_of(input logic [1:0] c);
		return (c == 2'h0) ? 11'h001 : (c == 2'h1) ? 11'h020 : (c == 2'h2) ? 11'h080 : 11'h400;
	endfunction

	task automatic wait_release();
		int n;
		n = 0;
		while (chip_reset !== 1'b0 && n < 400) begin
			tick(1);
			n++;
		end
		`check("release", 1'b1, n < 400)
		tick(2);
	endtask

	task automatic do_reset(input logic boot);
		boot_select_pin = boot;
		srst = 1'b1;
		tick(6);
		srst = 1'b0;
		wait_release();
	endtask

	task automatic check_defaults(input logic remap, input logic [2:0] cause);
		rd(mode_control_offset, d);
		`check("mode", {31'h0, remap}, d)
		rd(reset_cause_status_offset, d);
		`check("cause", {29'h0, cause}, d)
		`check("ctl", exp_ctl(32'h0, ~remap), ctl)
		`check("divisor", 11'h001, cpu_divisor)
	endtask

	// Waits for an internal reset, measures it and checks its cause
	task automatic await_reset(input logic [2:0] cause);
		int n;
		n = 0;
		while (chip_reset !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		n = 0;
		while (chip_reset === 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		`check("pulse_len", 1'b1, n >= 10 && n < 200)
		wait_release();
		rd(reset_cause_status_offset, d);
		`check("cause", {29'h0, cause}, d)
	endtask

	task automatic period(output int q);
		q = 0;
		while (cpu_clock_enable !== 1'b1 && q < 2100) begin
			tick(1);
			q++;
		end
		tick(1);
		q = 1;
		while (cpu_clock_enable !== 1'b1 && q < 2100) begin
			tick(1);
			q++;
		end
	endtask

	// Watchdog against a hung run, about twice the expected run length
	initial begin
		#400000;
		failures++;
		final_report();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = 22823;
		failures = 0;
		samples_checked = 0;
		srst = 1'b1;
		reset_pin = 1'b0;
		watchdog_pulse = 1'b0;
		boot_select_pin = 1'b0;
		bus_width_strap = 1'b1;
		boot_fail = 1'b0;
		req = '0;
		do_reset(1'b0);
		check_defaults(1'b0, cause_hardware);
		rd(chip_identification_offset, d);
		`check("ident", {15'h0, 1'b1, 13'h0, ver}, d)
		wr(chip_identification_offset, 32'hFFFFFFFF);
		rd(chip_identification_offset, d);
		`check("ident_ro", {15'h0, 1'b1, 13'h0, ver}, d)
		wr(reset_cause_status_offset, 32'hFFFFFFFF);
		rd(reset_cause_status_offset, d);
		`check("cause_rw", 32'h00000007, d)
		rd(4'hC, d);
		`check("unmapped", 32'h00000000, d)
		// Random and corner mode words
		for (int i = 0; i < 10; i++) begin
			w = (i == 0) ? mask : (i == 1) ? 32'h0 : ($random(seed) & mask);
			wr(mode_control_offset, w);
			tick(2);
			`check("ctl", exp_ctl(w, 1'b1), ctl)
			rd(mode_control_offset, d);
			`check("mode_rb", w, d)
		end
		// Release toggle sequence on both cores
		for (int i = 0; i < 6; i++) begin
			w = (i % 2 == 0) ? 32'h6 : 32'h0;
			wr(mode_control_offset, w);
			tick(2);
			`check("dsp_rel", {w[1], w[2]}, {ctl.dsp_a_reset_n, ctl.dsp_b_reset_n})
		end
		// Remap flag is set only
		wr(mode_control_offset, 32'h1);
		wr(mode_control_offset, 32'h0);
		tick(2);
		rd(mode_control_offset, d);
		`check("remap_set", 1'b1, d[boot_remap_flag_bit])
		`check("rom_off", 1'b0, ctl.rom_at_zero)
		// Failed serial boot falls back to external memory
		do_reset(1'b0);
		boot_fail = 1'b1;
		tick(1);
		boot_fail = 1'b0;
		tick(3);
		`check("boot_fail", 1'b0, ctl.rom_at_zero)
		// Low power for every divider code
		for (int c = 0; c < 4; c++) begin
			do_reset(1'b0);
			wr(mode_control_offset, 32'h40 | (c << 8));
			tick(3);
			`check("divisor", div_of(2'(c)), cpu_divisor)
			`check("dram_clk", 1'b0, ctl.dram_clock_run)
			wr(mode_control_offset, (c ^ 3) << 8);
			tick(3);
			`check("div_frozen", div_of(2'(c)), cpu_divisor)
			rd(mode_control_offset, d);
			`check("lp_sticky", 1'b1, d[low_power_flag_bit])
			period(p);
			`check("en_period", 32'(div_of(2'(c))), 32'(p))
		end
		// Software resets clear everything and force the remap flag to zero, then one
		bus_width_strap = 1'b0;
		for (int k = 0; k < 2; k++) begin
			boot_select_pin = (k == 0);
			wr(mode_control_offset, $random(seed) & mask);
			wr(mode_control_offset, 32'h1 << (k == 0 ? soft_reset_rom_on_bit : soft_reset_rom_off_bit));
			await_reset(cause_software);
			check_defaults(1'(k), cause_software);
		end
		rd(chip_identification_offset, d);
		`check("ident", {15'h0, 1'b0, 13'h0, ver}, d)
		// Watchdog reset
		tick(1);
		watchdog_pulse = 1'b1;
		tick(3);
		watchdog_pulse = 1'b0;
		await_reset(cause_watchdog);
		// Reset pin held the minimum length, ROM unmapped
		boot_select_pin = 1'b1;
		reset_pin = 1'b1;
		tick(10);
		reset_pin = 1'b0;
		tick(3);
		wait_release();
		check_defaults(1'b1, cause_hardware);
		// Long pin reset as needed with dynamic memory attached
		boot_select_pin = 1'b0;
		reset_pin = 1'b1;
		tick(25000);
		reset_pin = 1'b0;
		tick(3);
		wait_release();
		check_defaults(1'b0, cause_hardware);
		final_report();
	end
endmodule
